// ===== common/timer_pkg.sv
// constants, register map and field layout of the two channel timer
// =====================================================================
// Notes on behaviour
// R1: bus clock divided 1..64, code seven external
// R2: external clock pin forced to input
// R3: overflow flag sets when counter reaches modulo
// R4: overflow flag clears by read-then-write-zero only
// R5: overflow request when flag and enable set
// R6: halt bit freezes counter, set by reset
// R7: halt bit also blocks input captures
// R8: counter reset bit clears counter, prescaler, reads 0
// R9: halt plus counter reset leaves counter at zero
// R10: high byte read latches low byte buffer
// R11: counter restarts from zero after modulo
// R12: modulo high write blocks overflow until low write
// R13: channel flag on capture edge or compare match
// R14: channel flag clears by read-then-write-zero only
// R15: channel request when flag and enable set
// R16: buffered select only on channel 0, frees channel 1
// R17: edge code 00 leaves pin to port, preset level
// R18: capture edges rising, falling or both
// R19: unbuffered compare flags, toggles, clears or sets
// R20: buffered compare on channel 0 pin
// R21: software halts and resets counter before mode change
// R22: software resets counter before modulo writes
// R23: overflow toggle on compare channels
// R24: overflow action beats compare action
// R25: full duty force with overflow toggle
// R26: value high write blocks compare until low write
// R27: sixteen bit counter, one step per tick
// =====================================================================
package timer_pkg;
  // register byte addresses
  localparam logic [7:0] status_control_addr = 8'h00;
  localparam logic [7:0] counter_high_addr = 8'h04;
  localparam logic [7:0] counter_low_addr = 8'h08;
  localparam logic [7:0] modulo_high_addr = 8'h0c;
  localparam logic [7:0] modulo_low_addr = 8'h10;
  localparam logic [7:0] ch0_control_addr = 8'h14;
  localparam logic [7:0] ch0_value_high_addr = 8'h18;
  localparam logic [7:0] ch0_value_low_addr = 8'h1c;
  localparam logic [7:0] ch1_control_addr = 8'h20;
  localparam logic [7:0] ch1_value_high_addr = 8'h24;
  localparam logic [7:0] ch1_value_low_addr = 8'h28;
  // timer status/control fields
  localparam int ovf_flag_bit = 7;
  localparam int ovf_ie_bit = 6;
  localparam int halt_bit = 5;
  localparam int cnt_reset_bit = 4;
  localparam int clk_sel_lsb = 0;
  // channel status/control fields
  localparam int ch_flag_bit = 7;
  localparam int ch_ie_bit = 6;
  localparam int ch_msb_bit = 5;
  localparam int ch_msa_bit = 4;
  localparam int ch_elsb_bit = 3;
  localparam int ch_elsa_bit = 2;
  localparam int ch_tov_bit = 1;
  localparam int ch_max_bit = 0;
  // reset values and encodings
  localparam logic [15:0] modulo_reset = 16'hffff;
  localparam logic [2:0] clk_sel_external = 3'h7;
  localparam logic [1:0] els_port = 2'h0;
  localparam logic [1:0] els_toggle = 2'h1;
  localparam logic [1:0] els_clear = 2'h2;
  localparam logic [1:0] els_set = 2'h3;
  localparam int prescale_w = 7;
endpackage : timer_pkg

// ===== verilog/two_channel_timer_module.sv
// two channel 16-bit timer with apb register access
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module two_channel_timer_module
  import timer_pkg::*;
#(
  parameter int addr_w = 8 // apb address width
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_timer_clock_pin,
  output logic external_clock_input_force,
  input wire logic channel0_pin_in,
  output logic channel0_pin_out,
  output logic channel0_pin_oe,
  input wire logic channel1_pin_in,
  output logic channel1_pin_out,
  output logic channel1_pin_oe,
  output logic overflow_irq,
  output logic channel0_irq,
  output logic channel1_irq
);
  // =====================================================================
  // elaboration check
  if (addr_w < 8 || addr_w > 32) begin : g_bad_addr
    $error("addr_w must lie between 8 and 32");
  end
  // =====================================================================
  // state
  logic overflow_flag_r; // sticky overflow flag
  logic overflow_irq_enable_r; // overflow request enable
  logic counter_halt_r; // counter stop, set out of reset
  logic [2:0] clock_select_r; // prescaler / pin choice
  logic [15:0] counter_r; // the timer counter
  logic [prescale_w-1:0] prescale_r; // free divider
  logic [15:0] modulo_r; // wrap value
  logic modulo_hold_r; // high byte written, low pending
  logic ovf_armed_r; // flag seen set by a read
  logic [7:0] low_buf_r; // latched counter low byte
  logic low_latched_r; // buffer holds a value
  logic ext_prev_r; // last sample of external clock
  // per-channel state, index is channel number
  logic [1:0] ch_flag_r;
  logic [1:0] ch_ie_r;
  logic buffered_mode_select_r; // channel 0 only
  logic [1:0] ch_msa_r;
  logic [1:0] ch_elsb_r;
  logic [1:0] ch_elsa_r;
  logic [1:0] ch_tov_r;
  logic [1:0] ch_max_r;
  logic [1:0] ch_armed_r;
  logic [15:0] ch_value_r [2];
  logic [1:0] ch_block_r; // high byte written, compare held off
  logic [1:0] pin_prev_r; // last pin sample for edge detect
  logic [1:0] pin_level_r; // output level of each channel
  logic buf_active_r; // which value pair drives buffered mode
  logic buf_last_r; // value pair written last
  // =====================================================================
  // apb decode
  logic [7:0] word_addr; // byte address, low bits of paddr
  logic access; // access edge with the answer up
  logic wr_en;
  logic rd_en;
  logic mapped;
  assign word_addr = paddr[7:0];
  assign access = psel & penable & pready;
  assign wr_en = access & pwrite;
  assign rd_en = access & ~pwrite;

  // strobe helpers
  logic wr_tsc, rd_tsc, rd_cnt_hi, rd_cnt_lo, wr_mod_hi, wr_mod_lo;
  logic [1:0] wr_sc, rd_sc, wr_val_hi, wr_val_lo;
  logic ch1_enabled; // channel 1 not swallowed by buffered mode
  assign wr_tsc = wr_en && word_addr == status_control_addr;
  assign rd_tsc = rd_en && word_addr == status_control_addr;
  assign rd_cnt_hi = rd_en && word_addr == counter_high_addr;
  assign rd_cnt_lo = rd_en && word_addr == counter_low_addr;
  assign wr_mod_hi = wr_en && word_addr == modulo_high_addr;
  assign wr_mod_lo = wr_en && word_addr == modulo_low_addr;
  assign ch1_enabled = ~buffered_mode_select_r; // [R16]
  assign wr_sc[0] = wr_en && word_addr == ch0_control_addr;
  assign wr_sc[1] = wr_en && word_addr == ch1_control_addr && ch1_enabled;
  assign rd_sc[0] = rd_en && word_addr == ch0_control_addr;
  assign rd_sc[1] = rd_en && word_addr == ch1_control_addr && ch1_enabled;
  assign wr_val_hi[0] = wr_en && word_addr == ch0_value_high_addr;
  assign wr_val_hi[1] = wr_en && word_addr == ch1_value_high_addr;
  assign wr_val_lo[0] = wr_en && word_addr == ch0_value_low_addr;
  assign wr_val_lo[1] = wr_en && word_addr == ch1_value_low_addr;
  // =====================================================================
  // timer clock and counter events
  logic [prescale_w-1:0] div_mask; // ones below the chosen divide
  logic tick; // one enabled counter step
  logic overflow_evt; // counter sits at modulo on a tick
  logic cnt_reset; // counter reset bit written as one
  logic cnt_reset_bit_w;
  assign div_mask = prescale_w'((8'h1 << clock_select_r) - 8'h1);
  assign cnt_reset_bit_w = pwdata[cnt_reset_bit];
  assign cnt_reset = wr_tsc & cnt_reset_bit_w;
  // a tick never fires while halted; external pin counts rising edges
  always_comb begin
    if (clock_select_r == clk_sel_external) begin
      tick = ~counter_halt_r & external_timer_clock_pin & ~ext_prev_r; // [R1]
    end else begin
      tick = ~counter_halt_r & ((prescale_r & div_mask) == div_mask); // [R1] [R6]
    end
  end
  assign overflow_evt = tick & ~cnt_reset & (counter_r == modulo_r); // [R3]

  // prescaler, cleared along with the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_r <= '0;
    end else if (cnt_reset) begin
      prescale_r <= '0; // [R8]
    end else if (!counter_halt_r) begin
      prescale_r <= prescale_r + 1'b1;
    end
  end

  // external clock edge sampler, pin is taken as synchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= external_timer_clock_pin;
    end
  end

  // the counter itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_r <= '0;
    end else if (cnt_reset) begin
      counter_r <= '0; // [R8] [R9]
    end else if (overflow_evt) begin
      counter_r <= '0; // [R11]
    end else if (tick) begin
      counter_r <= counter_r + 16'h0001; // [R27]
    end
  end
  // =====================================================================
  // status/control register and overflow flag
  // counter reset bit is a strobe only; nothing stores it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable_r <= 1'b0; // [R5]
      counter_halt_r <= 1'b1; // [R6]
      clock_select_r <= '0;
    end else if (wr_tsc) begin
      overflow_irq_enable_r <= pwdata[ovf_ie_bit];
      counter_halt_r <= pwdata[halt_bit]; // [R6] [R9]
      clock_select_r <= pwdata[clk_sel_lsb +: 3];
    end
  end

  // sticky flag; a fresh overflow beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_r <= 1'b0;
      ovf_armed_r <= 1'b0;
    end else if (overflow_evt && !modulo_hold_r) begin
      overflow_flag_r <= 1'b1; // [R3] [R12]
      ovf_armed_r <= 1'b0; // [R4]
    end else if (wr_tsc) begin
      if (ovf_armed_r && !pwdata[ovf_flag_bit]) begin
        overflow_flag_r <= 1'b0; // [R4]
      end
      ovf_armed_r <= 1'b0;
    end else if (rd_tsc && prdata[ovf_flag_bit]) begin
      ovf_armed_r <= 1'b1; // [R4]
    end
  end
  // =====================================================================
  // modulo and counter read buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modulo_r <= modulo_reset; // [R12]
      modulo_hold_r <= 1'b0;
    end else if (wr_mod_hi) begin
      modulo_r[15:8] <= pwdata[7:0];
      modulo_hold_r <= 1'b1; // [R12]
    end else if (wr_mod_lo) begin
      modulo_r[7:0] <= pwdata[7:0];
      modulo_hold_r <= 1'b0; // [R12]
    end
  end

  // first high read latches the low byte; a low read releases it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_buf_r <= '0;
      low_latched_r <= 1'b0;
    end else if (cnt_reset) begin
      low_buf_r <= '0; // [R10]
      low_latched_r <= 1'b0;
    end else if (rd_cnt_hi && !low_latched_r) begin
      low_buf_r <= counter_r[7:0]; // [R10]
      low_latched_r <= 1'b1;
    end else if (rd_cnt_lo) begin
      low_latched_r <= 1'b0; // [R10]
    end
  end
  // =====================================================================
  // channel decode
  logic [1:0] pin_in; // both channel pins, channel 0 in bit 0
  logic [1:0] ch_msb; // buffered select seen per channel
  logic [1:0] ch_live; // channel takes part at all
  logic [1:0] ch_capture; // input capture mode
  logic [1:0] ch_compare; // any compare mode
  logic [1:0] ch_els [2];
  logic [1:0] cap_evt;
  logic [1:0] cmp_evt;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [15:0] cmp_value [2];
  logic [1:0] cmp_blocked;
  assign ch_msb = {1'b0, buffered_mode_select_r}; // [R16]
  assign ch_live = {ch1_enabled, 1'b1}; // [R16]
  assign pin_in = {channel1_pin_in, channel0_pin_in};

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ch_els[i] = {ch_elsb_r[i], ch_elsa_r[i]};
      rise[i] = pin_in[i] & ~pin_prev_r[i];
      fall[i] = ~pin_in[i] & pin_prev_r[i];
      ch_capture[i] = ch_live[i] & ~ch_msb[i] & ~ch_msa_r[i]
                      & (ch_els[i] != els_port);
      ch_compare[i] = ch_live[i] & (ch_msb[i] | ch_msa_r[i]);
      // buffered channel 0 compares against the active value pair
      cmp_value[i] = ch_value_r[i];
      cmp_blocked[i] = ch_block_r[i];
      if (i == 0 && ch_msb[0]) begin
        cmp_value[i] = ch_value_r[buf_active_r]; // [R20]
        cmp_blocked[i] = ch_block_r[buf_active_r];
      end
      // capture blocked while halted
      cap_evt[i] = ch_capture[i] & ~counter_halt_r // [R7]
                   & ((ch_elsa_r[i] & rise[i]) | (ch_elsb_r[i] & fall[i])); // [R18]
      cmp_evt[i] = ch_compare[i] & tick & ~cmp_blocked[i] // [R26]
                   & (counter_r == cmp_value[i]); // [R13]
    end
  end
  // =====================================================================
  // channel control registers and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_ie_r <= '0; // [R15]
      ch_msa_r <= '0; // [R17]
      ch_elsb_r <= '0;
      ch_elsa_r <= '0;
      ch_tov_r <= '0; // [R23]
      ch_max_r <= '0;
      buffered_mode_select_r <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_sc[i]) begin
          ch_ie_r[i] <= pwdata[ch_ie_bit];
          ch_msa_r[i] <= pwdata[ch_msa_bit];
          ch_elsb_r[i] <= pwdata[ch_elsb_bit];
          ch_elsa_r[i] <= pwdata[ch_elsa_bit];
          ch_tov_r[i] <= pwdata[ch_tov_bit];
          ch_max_r[i] <= pwdata[ch_max_bit];
        end
      end
      if (wr_sc[0]) begin
        buffered_mode_select_r <= pwdata[ch_msb_bit]; // [R16]
      end
    end
  end

  // sticky channel flags; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_flag_r <= '0;
      ch_armed_r <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_evt[i] || cmp_evt[i]) begin
          ch_flag_r[i] <= 1'b1; // [R13]
          ch_armed_r[i] <= 1'b0; // [R14]
        end else if (wr_sc[i]) begin
          if (ch_armed_r[i] && !pwdata[ch_flag_bit]) begin
            ch_flag_r[i] <= 1'b0; // [R14]
          end
          ch_armed_r[i] <= 1'b0;
        end else if (rd_sc[i] && prdata[ch_flag_bit]) begin
          ch_armed_r[i] <= 1'b1; // [R14]
        end
      end
    end
  end

  // value registers: capture loads them, software writes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_value_r[0] <= '0;
      ch_value_r[1] <= '0;
      ch_block_r <= '0;
      buf_last_r <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_evt[i]) begin
          ch_value_r[i] <= counter_r; // [R13]
        end else if (wr_val_hi[i]) begin
          ch_value_r[i][15:8] <= pwdata[7:0];
          ch_block_r[i] <= 1'b1; // [R26]
        end else if (wr_val_lo[i]) begin
          ch_value_r[i][7:0] <= pwdata[7:0];
          ch_block_r[i] <= 1'b0; // [R26]
          buf_last_r <= 1'(i);
        end
      end
    end
  end

  // buffered pair swaps in at the start of the next period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_active_r <= 1'b0;
    end else if (!buffered_mode_select_r) begin
      buf_active_r <= 1'b0;
    end else if (overflow_evt) begin
      buf_active_r <= buf_last_r; // [R20]
    end
  end
  // =====================================================================
  // channel output levels and pins
  // overflow toggle wins over compare; full duty overrides both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_r <= 2'b11;
      pin_prev_r <= '0;
    end else begin
      pin_prev_r <= {channel1_pin_in, channel0_pin_in};
      for (int i = 0; i < 2; i++) begin
        if (ch_els[i] == els_port) begin
          pin_level_r[i] <= ~ch_msa_r[i]; // [R17]
        end else if (!ch_compare[i]) begin
          pin_level_r[i] <= pin_level_r[i];
        end else if (ch_tov_r[i] && ch_max_r[i]) begin
          pin_level_r[i] <= (ch_els[i] != els_set); // [R25]
        end else if (ch_tov_r[i] && overflow_evt) begin
          pin_level_r[i] <= ~pin_level_r[i]; // [R23] [R24]
        end else if (cmp_evt[i]) begin
          case (ch_els[i])
            els_toggle: pin_level_r[i] <= ~pin_level_r[i]; // [R19] [R20]
            els_clear: pin_level_r[i] <= 1'b0; // [R19] [R20]
            els_set: pin_level_r[i] <= 1'b1; // [R19] [R20]
            default: pin_level_r[i] <= pin_level_r[i];
          endcase
        end
      end
    end
  end

  // pins driven only for compare with a non-zero edge code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel0_pin_out <= 1'b1;
      channel1_pin_out <= 1'b1;
      channel0_pin_oe <= 1'b0;
      channel1_pin_oe <= 1'b0;
      external_clock_input_force <= 1'b0;
    end else begin
      channel0_pin_out <= pin_level_r[0];
      channel1_pin_out <= pin_level_r[1];
      channel0_pin_oe <= ch_compare[0] && ch_els[0] != els_port; // [R17]
      channel1_pin_oe <= ch_compare[1] && ch_els[1] != els_port; // [R16]
      external_clock_input_force <= clock_select_r == clk_sel_external; // [R2]
    end
  end

  // interrupt requests follow flag and enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq <= 1'b0;
      channel0_irq <= 1'b0;
      channel1_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow_flag_r & overflow_irq_enable_r; // [R5]
      channel0_irq <= ch_flag_r[0] & ch_ie_r[0]; // [R15]
      channel1_irq <= ch_flag_r[1] & ch_ie_r[1] & ch1_enabled; // [R15]
    end
  end
  // =====================================================================
  // apb read data and handshake
  logic [7:0] rd_mux;
  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    case (word_addr)
      status_control_addr: rd_mux = {overflow_flag_r, overflow_irq_enable_r,
                                     counter_halt_r, 2'b00, clock_select_r}; // [R8]
      counter_high_addr: rd_mux = counter_r[15:8];
      counter_low_addr: rd_mux = low_latched_r ? low_buf_r : counter_r[7:0]; // [R10]
      modulo_high_addr: rd_mux = modulo_r[15:8];
      modulo_low_addr: rd_mux = modulo_r[7:0];
      ch0_control_addr: rd_mux = {ch_flag_r[0], ch_ie_r[0],
                                  buffered_mode_select_r, ch_msa_r[0],
                                  ch_elsb_r[0], ch_elsa_r[0], ch_tov_r[0],
                                  ch_max_r[0]};
      ch0_value_high_addr: rd_mux = ch_value_r[0][15:8];
      ch0_value_low_addr: rd_mux = ch_value_r[0][7:0];
      ch1_control_addr: rd_mux = ch1_enabled ? {ch_flag_r[1], ch_ie_r[1],
                                  1'b0, ch_msa_r[1], ch_elsb_r[1],
                                  ch_elsa_r[1], ch_tov_r[1], ch_max_r[1]}
                                  : 8'h00; // [R16]
      ch1_value_high_addr: rd_mux = ch_value_r[1][15:8];
      ch1_value_low_addr: rd_mux = ch_value_r[1][7:0];
      default: mapped = 1'b0;
    endcase
    if ((paddr >> 8) != '0) begin
      mapped = 1'b0;
    end
  end

  // no wait state: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_mux} : '0;
    end
  end

endmodule : two_channel_timer_module
`default_nettype wire

// ===== sim/timer_monitor.sv
// bus and pin checker bound to the two channel timer
`timescale 1ns/10ps
`default_nettype none
module timer_monitor
  import timer_pkg::*;
#(
  parameter int addr_w = 8 // apb address width
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_clock_input_force,
  input wire logic channel0_pin_oe,
  input wire logic overflow_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====================================================
  // bus handshake: one wait-free access per setup
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_error_with_ready: assert property (pslverr |-> pready && prdata == 0)
    else $error("error without ready or with data");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  // =====================================================
  // register and pin effects
  a_reset_bit_reads: assert property (pready && !pwrite &&
    paddr == status_control_addr |-> !prdata[cnt_reset_bit])
    else $error("counter reset bit read as one");
  a_ext_clock_force: assert property (psel && penable && pready && pwrite
    && paddr == status_control_addr && pwdata[2:0] == clk_sel_external
    |-> ##[1:3] external_clock_input_force)
    else $error("external clock pin not forced to input");
  a_irq_drop_cause: assert property ($fell(overflow_irq) |->
    $past(psel && pwrite, 1) || $past(psel && pwrite, 2))
    else $error("overflow request dropped without a write");
  a_oe_rise_cause: assert property ($rose(channel0_pin_oe) |->
    $past(psel && pwrite, 1) || $past(psel && pwrite, 2))
    else $error("channel pin driven without a write");
  // main scenarios reached
  c_overflow_irq: cover property (overflow_irq);
  c_refused: cover property (pslverr);
  c_pin_driven: cover property (channel0_pin_oe);
endmodule : timer_monitor
bind two_channel_timer_module timer_monitor #(.addr_w(addr_w)) monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .external_clock_input_force(external_clock_input_force),
  .channel0_pin_oe(channel0_pin_oe), .overflow_irq(overflow_irq));
`default_nettype wire

// ===== sim/test_two_channel_timer_module.sv
// self-checking bench for the two channel timer
`timescale 1ns/10ps
`default_nettype none
module test_two_channel_timer_module;
  import timer_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0; // byte address
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, ext_pin = 0, c0_in = 0, c1_in = 0, err;
  logic force_in, c0_out, c0_oe, c1_out, c1_oe, ovf_irq, c0_irq, c1_irq;
  logic [7:0] q, h; // last read byte, saved high byte
  int miscompares = 0, n_tests = 0, n;
  always #10 pclk = ~pclk;
  two_channel_timer_module DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_timer_clock_pin(ext_pin),
    .external_clock_input_force(force_in), .channel0_pin_in(c0_in),
    .channel0_pin_out(c0_out), .channel0_pin_oe(c0_oe),
    .channel1_pin_in(c1_in), .channel1_pin_out(c1_out),
    .channel1_pin_oe(c1_oe), .overflow_irq(ovf_irq),
    .channel0_irq(c0_irq), .channel1_irq(c1_irq));
  // =====================================================
  // checks and verdict
  task automatic chk(input string s, input logic [15:0] x, logic [15:0] g);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // =====================================================
  // apb master: hold request until ready, then one idle edge
  task automatic bus(input logic w, input logic [7:0] a, logic [7:0] d);
    int t;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) begin
      miscompares++;
      end_of_test();
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : bus
  task automatic wr(input logic [7:0] a, logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask : rd
  // watchdog, far beyond the expected run
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
  // =====================================================
  // main sequence
  initial begin
    void'($urandom(32'hde45));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(status_control_addr); chk("status reset", 16'h20, q);
    rd(modulo_high_addr); chk("modulo reset", 16'hff, q);
    rd(8'h3c); chk("unmapped error", 1, err);
    // each prescaler code: halt+reset, run a random span, halt
    for (int ps = 0; ps < 7; ps++) begin
      n = 100 + $urandom_range(200);
      wr(status_control_addr, 8'h30 | 8'(ps));
      rd(counter_low_addr); chk("count cleared", 0, q);
      wr(status_control_addr, 8'(ps));
      repeat (n) @(posedge pclk);
      wr(status_control_addr, 8'h20 | 8'(ps));
      rd(counter_high_addr);
      h = q;
      rd(counter_low_addr);
      chk("count", 16'((n + 3) >> ps), {h, q});
      rd(counter_high_addr); chk("count held", h, q);
    end
    // external clock: wide pulses, counted one to one
    wr(status_control_addr, 8'h37);
    wr(status_control_addr, 8'h07);
    n = 1 + $urandom_range(20);
    repeat (n) begin
      ext_pin <= 1;
      repeat (3) @(posedge pclk);
      ext_pin <= 0;
      repeat (3) @(posedge pclk);
    end
    chk("pin forced input", 1, force_in);
    wr(status_control_addr, 8'h27);
    rd(counter_high_addr);
    h = q;
    rd(counter_low_addr); chk("external count", n, {h, q});
    // overflow at modulo 0x3f with its request enabled
    wr(status_control_addr, 8'h30);
    wr(modulo_high_addr, 8'h00);
    wr(modulo_low_addr, 8'h3f);
    wr(status_control_addr, 8'h40);
    repeat (70) @(posedge pclk);
    chk("overflow request", 1, ovf_irq);
    wr(status_control_addr, 8'h40);
    rd(status_control_addr); chk("unarmed clear", 1, q[7]);
    wr(status_control_addr, 8'h40);
    rd(status_control_addr); chk("flag cleared", 0, q[7]);
    rd(counter_high_addr); chk("wraps at modulo", 0, q);
    wr(status_control_addr, 8'h50);
    wr(modulo_high_addr, 8'h00);
    repeat (140) @(posedge pclk);
    rd(status_control_addr); chk("modulo pending", 0, q[7]);
    wr(modulo_low_addr, 8'h3f);
    repeat (70) @(posedge pclk);
    rd(status_control_addr); chk("modulo done", 1, q[7]);
    // channel 0 compare at 0x20 for toggle, clear and set
    for (int c = 1; c < 4; c++) begin
      wr(status_control_addr, 8'h30);
      wr(ch0_value_high_addr, 8'h00);
      wr(ch0_value_low_addr, 8'h20);
      wr(ch0_control_addr, 8'h10 | 8'(c << 2));
      wr(status_control_addr, 8'h00);
      repeat (40) @(posedge pclk);
      // toggle flips the preset high level low, so only set ends high
      chk("compare level", 16'(c == 3), c0_out);
      chk("compare drive", 1, c0_oe);
      rd(ch0_control_addr); chk("compare flag", 1, q[7]);
    end
    // channel 1 rising capture, first while halted
    wr(status_control_addr, 8'h30);
    wr(ch1_control_addr, 8'h44);
    c1_in <= 1;
    repeat (4) @(posedge pclk);
    rd(ch1_control_addr); chk("halted capture", 0, q[7]);
    c1_in <= 0;
    wr(status_control_addr, 8'h00);
    c1_in <= 1;
    repeat (4) @(posedge pclk);
    chk("capture request", 1, c1_irq);
    rd(ch1_control_addr); chk("capture flag", 1, q[7]);
    // buffered select frees channel 1
    wr(ch0_control_addr, 8'h24);
    rd(ch1_control_addr); chk("channel 1 hidden", 0, q);
    chk("channel 1 released", 0, c1_oe);
    end_of_test();
  end
endmodule : test_two_channel_timer_module
`default_nettype wire
